// ===== logic/nlssm_top.sv
// nine-lane static shift memory with an output word fifo
`timescale 1ns/1ps
module nlssm_top #(
  parameter int LANE_LEN   = nlssm_pkg::LANE_LEN,
  parameter int FIFO_DEPTH = nlssm_pkg::FIFO_DEPTH
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 shift_clk,
  input  wire logic                 recirc_n,
  input  wire logic                 master_clear,
  input  wire nlssm_pkg::nlssm_word_s data_in,
  output nlssm_pkg::nlssm_word_s    data_out,
  output logic                      mon_valid,
  output nlssm_pkg::nlssm_word_s    mon_word,
  input  wire logic                 mon_ready,
  output logic                      shift_stalled
);

  localparam int LANES = nlssm_pkg::LANES;

  ////////////////////////////////////////////////////////////////////////////
  // shift-clock edge detection; every shift phase derives from this input

  logic                    shift_clk_reg;
  logic                    fall;
  nlssm_pkg::nlssm_state_e state_reg;
  logic [LANES-1:0]        held_in_reg;
  logic                    held_recirc_reg;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic [LANES-1:0]        fifo_out_data;
  logic                    do_shift;
  logic                    sel_recirc;
  logic [LANES-1:0]        sel_in;
  logic [LANES-1:0]        lane_tail;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      shift_clk_reg <= nlssm_pkg::SHIFT_CLK_RST;
    end
    else
    begin
      shift_clk_reg <= shift_clk;
    end
  end

  // only a high-to-low transition is an event; a clock held low does nothing
  assign fall = shift_clk_reg && !shift_clk;

  ////////////////////////////////////////////////////////////////////////////
  // shift sequencing: a falling edge that finds the fifo full is held,
  // with its inputs latched, until one word is drained; a further edge that arrives while one is held is lost

  // fully static: any edge spacing of at least one clk_sys cycle per phase is taken unless an earlier edge is still held
  assign do_shift = !master_clear && fifo_in_ready &&
                    ((state_reg == nlssm_pkg::NLSSM_HOLD) || fall);
  assign sel_recirc = (state_reg == nlssm_pkg::NLSSM_HOLD) ? held_recirc_reg : recirc_n;
  assign sel_in     = (state_reg == nlssm_pkg::NLSSM_HOLD) ? held_in_reg : data_in;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg       <= nlssm_pkg::NLSSM_IDLE;
      held_in_reg     <= nlssm_pkg::WORD_RST;
      held_recirc_reg <= 1'b0;
    end
    else if (master_clear)
    begin
      state_reg <= nlssm_pkg::NLSSM_IDLE;
    end
    else
    begin
      case (state_reg)
        nlssm_pkg::NLSSM_IDLE,
        nlssm_pkg::NLSSM_SHIFT:
        begin
          if (fall && !fifo_in_ready)
          begin
            state_reg       <= nlssm_pkg::NLSSM_HOLD;
            held_in_reg     <= data_in;
            held_recirc_reg <= recirc_n;
          end
          else
          begin
            state_reg <= fall ? nlssm_pkg::NLSSM_SHIFT : nlssm_pkg::NLSSM_IDLE;
          end
        end
        nlssm_pkg::NLSSM_HOLD:
        begin
          if (fifo_in_ready)
          begin
            state_reg <= nlssm_pkg::NLSSM_SHIFT;
          end
        end
        default:
        begin
          state_reg <= nlssm_pkg::NLSSM_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the nine lanes, shared shift and recirculate, own data in and out

  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++)
    begin : g_lane
      logic [LANE_LEN-1:0] lane_reg;

      always_ff @(posedge clk_sys)
      begin
        if (rst || master_clear)
        begin
          lane_reg <= '0;
        end
        else if (do_shift)
        begin
          // recirculate low feeds the lane's own tail back to its head
          lane_reg <= {lane_reg[LANE_LEN-2:0],
                       sel_recirc ? sel_in[gi] : lane_reg[LANE_LEN-1]};
        end
      end

      assign lane_tail[gi] = lane_reg[LANE_LEN-1];
    end
  endgenerate

  // data_out is the last stage flip-flop of each lane
  assign data_out = lane_tail;

  ////////////////////////////////////////////////////////////////////////////
  // monitor fifo: each word leaving the last stage on a shift is queued;
  // a full fifo defers shifts, which bounds the usable rate to the drain rate

  nlssm_fifo #(
    .WIDTH (LANES),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst || master_clear),
    .in_valid  (do_shift),
    .in_data   (lane_tail),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (mon_ready)
  );

  assign mon_valid     = fifo_out_valid;
  assign mon_word      = fifo_out_data;
  assign shift_stalled = (state_reg == nlssm_pkg::NLSSM_HOLD);

endmodule

// ===== include/nlssm_pkg.sv
// shared constants and types for the nine-lane static shift memory
package nlssm_pkg;

  // geometry
  localparam int LANES       = 9;
  localparam int DATA_BITS   = 8;
  localparam int LANE_LEN    = 80;
  localparam int FIFO_DEPTH  = 16;

  // timing: clk_sys rate and the shift-clock ceiling
  localparam int SYS_CLK_HZ   = 100_000_000;
  localparam int SHIFT_MAX_HZ = 1_500_000;
  localparam int SHIFT_MIN_PERIOD_CYC = (SYS_CLK_HZ + SHIFT_MAX_HZ - 1) / SHIFT_MAX_HZ;

  // release of master clear ahead of the next rising shift clock
  localparam int CLR_SETUP_NS  = 250;
  localparam int CLR_SETUP_CYC = (CLR_SETUP_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

  // reset values
  localparam logic       SHIFT_CLK_RST = 1'b0;
  localparam logic [8:0] WORD_RST      = 9'h000;

  // one stored word: eight data bits plus a marker or parity bit
  typedef struct packed {
    logic                 marker;
    logic [DATA_BITS-1:0] data;
  } nlssm_word_s;

  // shift request state
  typedef enum logic [1:0] {
    NLSSM_IDLE  = 2'b00,
    NLSSM_SHIFT = 2'b01,
    NLSSM_HOLD  = 2'b10
  } nlssm_state_e;

endpackage

// ===== logic/nlssm_fifo.sv
// parameterised valid/ready fifo built from flip-flops
`timescale 1ns/1ps
module nlssm_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      case ({push, pop})
        2'b10:   count_reg <= count_reg + 1'b1;
        2'b01:   count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end

endmodule

// ===== sim/nlssm_asserts.sv
// assertion checker on the shift memory top ports
`timescale 1ns/1ps
module nlssm_asserts #(
  parameter int LANE_LEN   = 4,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire logic                   shift_clk,
  input wire logic                   recirc_n,
  input wire logic                   master_clear,
  input wire nlssm_pkg::nlssm_word_s data_in,
  input wire nlssm_pkg::nlssm_word_s data_out,
  input wire logic                   mon_valid,
  input wire nlssm_pkg::nlssm_word_s mon_word,
  input wire logic                   mon_ready,
  input wire logic                   shift_stalled
);
  logic clk_seen_reg;
  logic fell;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  always_ff @(posedge clk_sys)
    clk_seen_reg <= rst ? 1'b0 : shift_clk;
  assign fell = clk_seen_reg && !shift_clk;
  //////////////////////////////////////////////////////////////////
  sequence shift_s;
    fell && !master_clear && !shift_stalled;
  endsequence
  sequence pop_s;
    shift_stalled && mon_valid && mon_ready && !master_clear;
  endsequence
  clear_zeroes_a: assert property (master_clear |=> data_out == 9'h000)
    else $error("lanes not cleared");
  clear_flush_a: assert property (master_clear |=> !mon_valid && !shift_stalled)
    else $error("state kept over clear");
  // a clear may still move the outputs without a shift edge, so it is excluded
  hold_still_a: assert property (!fell && !shift_stalled && !master_clear |=> $stable(data_out))
    else $error("output moved without edge");
  shift_push_a: assert property (shift_s ##0 !mon_valid |=> mon_word == $past(data_out))
    else $error("pushed word wrong");
  stall_cause_a: assert property ($rose(shift_stalled) |-> $past(fell))
    else $error("stall without edge");
  stall_hold_a: assert property (shift_stalled |-> $stable(data_out))
    else $error("output moved while stalled");
  stall_ends_a: assert property (pop_s |-> ##[1:2] !shift_stalled)
    else $error("stall not released");
  head_hold_a: assert property (mon_valid && !mon_ready && !master_clear |=> $stable(mon_word))
    else $error("head changed unpopped");
endmodule

bind nlssm_top nlssm_asserts #(.LANE_LEN(LANE_LEN), .FIFO_DEPTH(FIFO_DEPTH)) chk_i (
  .clk_sys(clk_sys), .rst(rst), .shift_clk(shift_clk), .recirc_n(recirc_n),
  .master_clear(master_clear), .data_in(data_in), .data_out(data_out),
  .mon_valid(mon_valid), .mon_word(mon_word), .mon_ready(mon_ready),
  .shift_stalled(shift_stalled));

// ===== sim/nlssm_ctrl_model.sv
// controller model: one shift clock pulse per request
`timescale 1ns/1ps
module nlssm_ctrl_model #(
  parameter int HALF = 34
) (
  input  wire logic clk_sys,
  input  wire logic go,
  output logic      shift_clk,
  output logic      busy
);
  int cnt = 0;
  initial shift_clk = 1'b0;
  initial busy = 1'b0;
  // 69-cycle period keeps the rate under the ceiling; clock rests low
  always @(negedge clk_sys)
    if (cnt != 0)
    begin
      cnt <= cnt - 1;
      shift_clk <= cnt > HALF + 1;
      busy <= cnt != 1;
    end
    else if (go)
    begin
      cnt <= 2 * HALF;
      shift_clk <= 1'b1;
      busy <= 1'b1;
    end
endmodule

// ===== sim/nlssm_tb.sv
// self-checking bench for the shift memory
`timescale 1ns/1ps
module testbench;
  localparam int N = 4;
  logic                   clk_sys = 1'b0;
  logic                   rst = 1'b1;
  logic                   recirc_n = 1'b1;
  logic                   master_clear = 1'b0;
  logic                   mon_ready = 1'b1;
  logic                   go = 1'b0;
  logic                   shift_clk;
  logic                   busy;
  logic                   mon_valid;
  logic                   shift_stalled;
  nlssm_pkg::nlssm_word_s data_in = 9'h000;
  nlssm_pkg::nlssm_word_s data_out;
  nlssm_pkg::nlssm_word_s mon_word;
  logic [8:0]             w [8];
  int                     mismatches = 0;
  int                     checks = 0;
  int                     cyc = 0;
  always #5 clk_sys = ~clk_sys;
  nlssm_ctrl_model ctl (.clk_sys(clk_sys), .go(go), .shift_clk(shift_clk), .busy(busy));
  nlssm_top #(.LANE_LEN(N), .FIFO_DEPTH(N)) dut (.clk_sys(clk_sys), .rst(rst),
    .shift_clk(shift_clk), .recirc_n(recirc_n), .master_clear(master_clear),
    .data_in(data_in), .data_out(data_out), .mon_valid(mon_valid), .mon_word(mon_word),
    .mon_ready(mon_ready), .shift_stalled(shift_stalled));
  //////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // inputs held until the next request, well past the falling edge
  task pulse(input logic r, input logic [8:0] d);
    @(negedge clk_sys);
    recirc_n <= r;
    data_in <= d;
    go <= 1'b1;
    @(negedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    while (busy)
      @(posedge clk_sys);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////
  task t_load;
    for (int i = 0; i < N; i++)
    begin
      pulse(1'b1, w[i]);
      chk("load", data_out, (i == N - 1) ? w[0] : 9'h000);
    end
    $display("test load done");
  endtask
  task t_recirc;
    for (int i = 1; i <= N; i++)
    begin
      pulse(1'b0, ~w[i]);
      chk("recirc", data_out, w[i % N]);
    end
    $display("test recirc done");
  endtask
  // a full fifo defers the fifth shift until one word is drained
  task t_stall;
    @(negedge clk_sys);
    mon_ready <= 1'b0;
    for (int i = 0; i <= N; i++)
      pulse(1'b0, 9'h1ff);
    chk("stalled", {8'h00, shift_stalled}, 9'h001);
    chk("mon_valid", {8'h00, mon_valid}, 9'h001);
    chk("held", data_out, w[0]);
    for (int i = 0; i <= N; i++)
    begin
      @(negedge clk_sys);
      chk("pop", mon_word, w[i % N]);
      mon_ready <= 1'b1;
      @(negedge clk_sys);
      mon_ready <= 1'b0;
    end
    chk("resumed", data_out, w[1]);
    @(negedge clk_sys);
    mon_ready <= 1'b1;
    $display("test stall done");
  endtask
  task t_clear;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk_sys);
      recirc_n <= i[0];
      data_in <= w[i];
    end
    chk("idle", data_out, w[1]);
    go <= 1'b1;
    @(negedge clk_sys);
    go <= 1'b0;
    repeat (3) @(negedge clk_sys);
    master_clear <= 1'b1;
    @(negedge clk_sys);
    master_clear <= 1'b0;
    chk("clear", data_out, 9'h000);
    while (busy)
      @(negedge clk_sys);
    chk("after", data_out, 9'h000);
    $display("test clear done");
  endtask
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      conclude;
    end
  end
  initial
  begin
    for (int i = 0; i < 8; i++)
      w[i] = 9'h0a5 + 9'(i) * 9'h053;
    repeat (8) @(negedge clk_sys);
    rst <= 1'b0;
    t_load;
    t_recirc;
    t_stall;
    t_clear;
    conclude;
  end
endmodule
